/* design/scpi_error_and_system_setup.sv */
`timescale 1ns/1ps
module scpi_error_and_system_setup #(
    parameter int QUEUE_DEPTH   = 16,
    parameter int COUNT_WIDTH   = 8,
    parameter logic [7:0] VERSION_REV = 8'h00
) (
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    input  wire scpi_err_pkg::events_t        events_in,
    input  wire logic                         protected_access_unlock_in,
    input  wire logic                         calibration_state_in,
    input  wire logic [COUNT_WIDTH-1:0]       step_hold_count_in,
    input  wire logic [COUNT_WIDTH-1:0]       table_count_in,
    input  wire logic [8:0]                   response_length_in,
    input  wire logic [1:0]                   output_error_check_mode_in,
    input  wire logic                         error_read_in,
    input  wire logic                         status_clear_in,
    input  wire logic                         behaviour_setting_command_in,
    input  wire scpi_err_pkg::setting_code_t  setting_code_in,
    input  wire logic                         security_immediate_command_in,
    input  wire logic                         behaviour_setting_query_in,
    input  wire logic                         version_query_in,
    input  wire logic                         reset_cmd_in,
    input  wire logic                         device_clear_in,
    input  wire logic                         output_on_cmd_in,
    input  wire logic                         output_off_cmd_in,
    input  wire logic                         empty_read_in,
    output logic signed [15:0]                error_code_out,
    output logic                              error_valid_out,
    output logic [7:0]                        event_status_out,
    output logic                              command_reject_out,
    output logic                              response_drop_out,
    output scpi_err_pkg::options_t            setting_reply_out,
    output logic                              setting_valid_out,
    output logic [15:0]                       version_year_out,
    output logic [7:0]                        version_rev_out,
    output logic                              version_valid_out,
    output logic [7:0]                        read_char_out,
    output logic                              read_valid_out,
    output logic                              output_on_out,
    output logic                              voltage_mode_out,
    output logic                              setpoint_zero_out
);
    import scpi_err_pkg::*;

    localparam int PTR_W = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
    localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(QUEUE_DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(QUEUE_DEPTH - 1);

    // ==========================================================================
    // event qualification
    logic            protect_hit;
    logic            conflict_hit;
    logic            list_len_hit;
    logic            window_check_on;
    logic            volt_hit;
    logic            curr_hit;
    logic            resp_hit;
    logic            reset_now;
    logic            clear_status;
    logic            new_error;
    logic signed [15:0] new_code;
    logic [7:0]      esr_set;

    // queue state and options, declared ahead of their first readers
    logic [CNT_W-1:0] count;
    logic             queue_lost;
    options_t         options;

    // conditions that turn an event pulse into a logged failure
    assign protect_hit     = events_in.protected_cmd & ~protected_access_unlock_in;
    assign conflict_hit    = (events_in.calibrate_cmd & ~calibration_state_in)
                           | events_in.list_descending;
    assign list_len_hit    = events_in.list_loaded
                           & (step_hold_count_in != COUNT_WIDTH'(1))
                           & (step_hold_count_in != table_count_in);
    assign window_check_on = output_error_check_mode_in != 2'h0;
    assign volt_hit        = events_in.voltage_window_fail & window_check_on;
    assign curr_hit        = events_in.current_window_fail & window_check_on;
    assign resp_hit        = events_in.response_done
                           & (response_length_in > RESP_LIMIT);

    // device clear with clear option 1 behaves as a reset
    assign reset_now    = reset_cmd_in
                        | (device_clear_in & options.clear_acts_as_reset_option);
    assign clear_status = status_clear_in | device_clear_in;

    // pick one code per cycle, the first in this order wins
    // every event of the cycle but discovery_connect still sets its status bit below
    always_comb begin
        new_error = 1'b1;
        if (events_in.parse_fail)              new_code = ERR_COMMAND;
        else if (events_in.param_missing)      new_code = ERR_MISSING;
        else if (events_in.numeric_bad)        new_code = ERR_NUMERIC;
        else if (protect_hit)                  new_code = ERR_PROTECTED;
        else if (conflict_hit)                 new_code = ERR_CONFLICT;
        else if (events_in.value_out_of_range) new_code = ERR_RANGE;
        else if (events_in.list_table_full)    new_code = ERR_TOO_MUCH;
        else if (list_len_hit)                 new_code = ERR_LIST_LEN;
        else if (events_in.stage_no_answer)    new_code = ERR_HARDWARE;
        else if (events_in.discovery_connect)  new_code = ERR_DISCOVERY;
        else if (volt_hit)                     new_code = ERR_VOLTAGE;
        else if (curr_hit)                     new_code = ERR_CURRENT;
        else if (events_in.memory_fail)        new_code = ERR_MEMORY;
        else if (resp_hit)                     new_code = ERR_QUERY;
        else if (events_in.query_unread)       new_code = ERR_UNTERM;
        else begin
            new_error = 1'b0;
            new_code  = ERR_NONE;
        end
    end

    // status bits from every event of the cycle except discovery_connect, not only the queued one
    always_comb begin
        esr_set = 8'h00;
        esr_set[ESR_COMMAND_BIT] = events_in.parse_fail | events_in.param_missing
                                 | events_in.numeric_bad;
        esr_set[ESR_EXEC_BIT]    = protect_hit | conflict_hit
                                 | events_in.value_out_of_range
                                 | events_in.list_table_full | list_len_hit
                                 | events_in.stage_no_answer;
        esr_set[ESR_DEVICE_BIT]  = volt_hit | curr_hit | events_in.memory_fail
                                 | queue_lost;
        esr_set[ESR_QUERY_BIT]   = resp_hit | events_in.query_unread;
    end

    // ==========================================================================
    // error queue
    logic signed [15:0] queue [QUEUE_DEPTH];
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic               do_pop;
    logic               do_push;
    logic [PTR_W-1:0]   newest_ptr;
    logic [PTR_W-1:0]   push_ptr;

    // a clear restarts the queue, keeping an error of its own cycle in slot 0
    assign do_pop     = error_read_in & (count != '0);
    assign do_push    = new_error & (clear_status | (count != FULL_COUNT) | do_pop);
    assign queue_lost = new_error & ~do_push;
    assign newest_ptr = (wr_ptr == '0) ? LAST_PTR : wr_ptr - PTR_W'(1);
    assign push_ptr   = clear_status ? '0 : wr_ptr;

    // storage; a full queue overwrites its newest entry with the overflow code
    // no reset: a slot is read only after it has been written
    always_ff @(posedge clk_in) begin
        if (do_push)
            queue[push_ptr] <= new_code;
        else if (queue_lost)
            queue[newest_ptr] <= ERR_OVERFLOW;
    end

    // read and write pointers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (clear_status) begin
            wr_ptr <= (new_error & (LAST_PTR != '0)) ? PTR_W'(1) : '0;
            rd_ptr <= '0;
        end else begin
            if (do_push)
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PTR_W'(1);
            if (do_pop)
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PTR_W'(1);
        end
    end

    // fill level; an error in a clear cycle survives the clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            count <= '0;
        else if (clear_status)
            count <= new_error ? CNT_W'(1) : '0;
        else if (do_push & ~do_pop)
            count <= count + CNT_W'(1);
        else if (do_pop & ~do_push)
            count <= count - CNT_W'(1);
    end

    // read port: oldest entry, or zero when empty
    // the code holds until the next read
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            error_code_out  <= ERR_NONE;
            error_valid_out <= 1'b0;
        end else begin
            error_valid_out <= error_read_in;
            if (error_read_in)
                error_code_out <= (count != '0) ? queue[rd_ptr] : ERR_NONE;
        end
    end

    // ==========================================================================
    // event status register; a new event wins over a clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            event_status_out <= ESR_RESET;
        else if (clear_status)
            event_status_out <= esr_set;
        else
            event_status_out <= event_status_out | esr_set;
    end

    // rejection and lost-response flags
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            command_reject_out <= 1'b0;
            response_drop_out  <= 1'b0;
        end else begin
            command_reject_out <= protect_hit;
            response_drop_out  <= resp_hit;
        end
    end

    // ==========================================================================
    // behaviour options
    // a security command wins over a setting command in the same cycle

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            options <= OPTIONS_RESET;
        end else if (security_immediate_command_in) begin
            options <= '{clear_acts_as_reset_option: 1'b0,
                         empty_read_newline_option:  1'b1,
                         reset_output_on_option:     1'b0};
        end else if (behaviour_setting_command_in) begin
            unique case (setting_code_in)
                SET_STANDARDS: options <= 3'h0;
                SET_LEGACY:    options <= 3'h7;
                SET_CLR_ONLY:  options.clear_acts_as_reset_option <= 1'b0;
                SET_CLR_RESET: options.clear_acts_as_reset_option <= 1'b1;
                SET_NL_OFF:    options.empty_read_newline_option  <= 1'b0;
                SET_NL_ON:     options.empty_read_newline_option  <= 1'b1;
                SET_OUT_OFF:   options.reset_output_on_option     <= 1'b0;
                SET_OUT_ON:    options.reset_output_on_option     <= 1'b1;
            endcase
        end
    end

    // setting query; the reply holds until the next query
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            setting_reply_out <= OPTIONS_RESET;
            setting_valid_out <= 1'b0;
        end else begin
            setting_valid_out <= behaviour_setting_query_in;
            if (behaviour_setting_query_in)
                setting_reply_out <= options;
        end
    end

    // version query; year and revision hold until the next query
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            version_year_out  <= 16'h0000;
            version_rev_out   <= 8'h00;
            version_valid_out <= 1'b0;
        end else begin
            version_valid_out <= version_query_in;
            if (version_query_in) begin
                version_year_out <= VERSION_YEAR;
                version_rev_out  <= VERSION_REV;
            end
        end
    end

    // empty-buffer read: newline only with the newline option set
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            read_char_out  <= 8'h00;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= empty_read_in & options.empty_read_newline_option;
            read_char_out  <= NEWLINE_CHAR;
        end
    end

    // ==========================================================================
    // output state; power-up always comes up off in voltage mode
    // a reset command wins over every other command of its cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            output_on_out     <= 1'b0;
            voltage_mode_out  <= 1'b1;
            setpoint_zero_out <= 1'b1;
        end else if (reset_now) begin
            output_on_out     <= options.reset_output_on_option;
            voltage_mode_out  <= 1'b1;
            setpoint_zero_out <= 1'b1;
        end else begin
            setpoint_zero_out <= 1'b0;
            if (volt_hit | curr_hit)
                output_on_out <= 1'b0;
            else if (output_off_cmd_in)
                output_on_out <= 1'b0;
            else if (output_on_cmd_in)
                output_on_out <= 1'b1;
        end
    end

endmodule

/* pkg/scpi_err_pkg.sv */
//==============================================================================
package scpi_err_pkg;

    // ==========================================================================
    // error codes
    localparam logic signed [15:0] ERR_NONE        = 16'sh0000;
    localparam logic signed [15:0] ERR_COMMAND     = -16'sh0064;   // -100
    localparam logic signed [15:0] ERR_MISSING     = -16'sh006D;   // -109
    localparam logic signed [15:0] ERR_NUMERIC     = -16'sh0078;   // -120
    localparam logic signed [15:0] ERR_PROTECTED   = -16'sh00CB;   // -203
    localparam logic signed [15:0] ERR_CONFLICT    = -16'sh00DD;   // -221
    localparam logic signed [15:0] ERR_RANGE       = -16'sh00DE;   // -222
    localparam logic signed [15:0] ERR_TOO_MUCH    = -16'sh00DF;   // -223
    localparam logic signed [15:0] ERR_LIST_LEN    = -16'sh00E2;   // -226
    localparam logic signed [15:0] ERR_HARDWARE    = -16'sh00F0;   // -240
    localparam logic signed [15:0] ERR_DISCOVERY   = -16'sh00F1;   // -241
    localparam logic signed [15:0] ERR_VOLTAGE     = -16'sh012D;   // -301
    localparam logic signed [15:0] ERR_CURRENT     = -16'sh012E;   // -302
    localparam logic signed [15:0] ERR_MEMORY      = -16'sh0137;   // -311
    localparam logic signed [15:0] ERR_OVERFLOW    = -16'sh015E;   // -350
    localparam logic signed [15:0] ERR_QUERY       = -16'sh0190;   // -400
    localparam logic signed [15:0] ERR_UNTERM      = -16'sh01A4;   // -420

    // ==========================================================================
    // event status bit positions
    localparam int ESR_QUERY_BIT   = 2;
    localparam int ESR_DEVICE_BIT  = 3;
    localparam int ESR_EXEC_BIT    = 4;
    localparam int ESR_COMMAND_BIT = 5;
    localparam logic [7:0] ESR_RESET = 8'h00;

    // ==========================================================================
    // limits and identity
    localparam logic [8:0]  RESP_LIMIT   = 9'h0FD;   // 253 characters
    localparam logic [15:0] VERSION_YEAR = 16'h07CD; // 1997
    localparam logic [7:0]  NEWLINE_CHAR = 8'h0A;

    // ==========================================================================
    // behaviour options
    typedef struct packed {
        logic clear_acts_as_reset_option;   // device-clear option
        logic empty_read_newline_option;    // line-feed option
        logic reset_output_on_option;       // reset-output option
    } options_t;

    localparam options_t OPTIONS_RESET = 3'h0;

    typedef enum logic [2:0] {
        SET_STANDARDS = 3'h0,   // standards_compliance_choice
        SET_LEGACY    = 3'h1,   // legacy_compatibility_choice
        SET_CLR_ONLY  = 3'h2,   // clear_status_only_option
        SET_CLR_RESET = 3'h3,   // clear_acts_as_reset_option
        SET_NL_OFF    = 3'h4,   // no_empty_read_newline_option
        SET_NL_ON     = 3'h5,   // empty_read_newline_option
        SET_OUT_OFF   = 3'h6,   // reset_output_off_option
        SET_OUT_ON    = 3'h7    // reset_output_on_option
    } setting_code_t;

    // ==========================================================================
    // failure events, one-cycle pulses from the parser and the instrument
    typedef struct packed {
        logic parse_fail;
        logic param_missing;
        logic numeric_bad;
        logic protected_cmd;
        logic calibrate_cmd;
        logic list_descending;
        logic value_out_of_range;
        logic list_table_full;
        logic list_loaded;
        logic stage_no_answer;
        logic discovery_connect;
        logic voltage_window_fail;
        logic current_window_fail;
        logic memory_fail;
        logic response_done;
        logic query_unread;
    } events_t;

endpackage

/* tb/scpi_props.sv */
`timescale 1ns/1ps
// ======================================
// port checker for error and setup logic
module scpi_props (
    input logic                  clk_in,
    input logic                  rst_b_in,
    input scpi_err_pkg::events_t events_in,
    input logic                  protected_access_unlock_in,
    input logic [8:0]            response_length_in,
    input logic [1:0]            output_error_check_mode_in,
    input logic                  security_immediate_command_in,
    input logic                  empty_read_in,
    input logic                  reset_cmd_in,
    input logic                  device_clear_in,
    input logic                  status_clear_in,
    input logic                  version_query_in,
    input logic [7:0]            event_status_out,
    input logic                  command_reject_out,
    input logic                  response_drop_out,
    input logic [7:0]            read_char_out,
    input logic                  read_valid_out,
    input logic                  output_on_out,
    input logic                  voltage_mode_out,
    input logic                  setpoint_zero_out,
    input logic [15:0]           version_year_out,
    input logic                  version_valid_out
);
    import scpi_err_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // ======================================
    // stimulus shapes, one multi-step and one single-cycle
    sequence sec_then_read;
        security_immediate_command_in ##1 empty_read_in;
    endsequence
    sequence window_hit;
        (events_in.voltage_window_fail || events_in.current_window_fail) &&
            events_in[15:5] == 11'h000 && output_error_check_mode_in != 2'h0 &&
            !reset_cmd_in && !device_clear_in;
    endsequence

    // ======================================
    // status, replies and output
    AST_CMD_BIT: assert property (events_in.parse_fail |=> event_status_out[5])
        else $error("command error bit missing");
    AST_PROTECT: assert property (events_in.protected_cmd |=>
        command_reject_out != $past(protected_access_unlock_in)) else $error("bad reject");
    AST_QUERY_DROP: assert property (events_in.response_done && response_length_in > 9'h0FD
        |=> response_drop_out && event_status_out[2]) else $error("long reply not dropped");
    AST_MEMORY: assert property (events_in.memory_fail |=> event_status_out[3])
        else $error("memory error bit missing");
    AST_NO_BIT: assert property (events_in == 16'h0020 && !status_clear_in &&
        !device_clear_in && !reset_cmd_in |=> $stable(event_status_out)) else $error("bit set");
    AST_NEWLINE: assert property (sec_then_read |=> read_valid_out &&
        read_char_out == 8'h0A) else $error("no newline after security command");
    AST_RESET_OUT: assert property (reset_cmd_in |=> voltage_mode_out && setpoint_zero_out)
        else $error("reset did not force 0V voltage mode");
    AST_WINDOW_OFF: assert property (window_hit |=> !output_on_out)
        else $error("output left on after window failure");
    AST_VERSION: assert property (version_query_in |=> version_valid_out &&
        version_year_out == 16'h07CD) else $error("bad version reply");
endmodule

bind scpi_error_and_system_setup scpi_props i_scpi_props (.*);

/* tb/host_reader.sv */
`timescale 1ns/1ps
// ======================================
// remote host: takes each reply offered
module host_reader (
    input  logic       clk_in,
    input  logic       rst_b_in,
    input  logic       reply_valid_in,
    output logic [7:0] replies_taken_out
);
    // read every reply in its cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            replies_taken_out <= 8'h00;
        end else if (reply_valid_in) begin
            replies_taken_out <= replies_taken_out + 8'h01;
        end
    end
endmodule

/* tb/scpi_error_and_system_setup_bench.sv */
`timescale 1ns/1ps
// ======================================
// bench for error and setup logic
module scpi_error_and_system_setup_bench;
    import scpi_err_pkg::*;
    localparam int DEPTH = 16;
    logic clk_in = 1'h0, rst_b_in = 1'h0;
    events_t events_in = '0;
    logic protected_access_unlock_in = 1'h0, calibration_state_in = 1'h0;
    logic [7:0] step_hold_count_in = 8'h03, table_count_in = 8'h05;
    logic [8:0] response_length_in = 9'h0FE;
    logic [1:0] output_error_check_mode_in = 2'h1;
    setting_code_t setting_code_in = SET_STANDARDS;
    logic error_read_in = 1'h0, status_clear_in = 1'h0, behaviour_setting_command_in = 1'h0;
    logic security_immediate_command_in = 1'h0, behaviour_setting_query_in = 1'h0;
    logic version_query_in = 1'h0, reset_cmd_in = 1'h0, device_clear_in = 1'h0;
    logic output_on_cmd_in = 1'h0, output_off_cmd_in = 1'h0, empty_read_in = 1'h0;
    logic signed [15:0] error_code_out;
    logic [15:0] version_year_out;
    logic [7:0] event_status_out, version_rev_out, read_char_out, replies;
    options_t setting_reply_out;
    logic error_valid_out, command_reject_out, response_drop_out, setting_valid_out;
    logic version_valid_out, read_valid_out, output_on_out, voltage_mode_out, setpoint_zero_out;
    int num_errors = 0, cmp_count = 0;

    // ======================================
    // unit and remote host
    scpi_error_and_system_setup #(.QUEUE_DEPTH(DEPTH)) i_scpi_error_and_system_setup (.*);
    host_reader i_host_reader (.clk_in, .rst_b_in, .replies_taken_out(replies),
        .reply_valid_in(setting_valid_out | version_valid_out));

    // 100 ns clock
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // ======================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk(16'(got), 16'(exp));
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_in) s = 1'h1;
        @(negedge clk_in) s = 1'h0;
    endtask
    task automatic fire(input events_t e);
        @(negedge clk_in) events_in = e;
        @(negedge clk_in) events_in = '0;
    endtask
    task automatic pop(input logic [15:0] exp);
        pulse(error_read_in);
        chkb(error_valid_out, 1'h1);
        chk(error_code_out, exp);
    endtask
    task automatic qset(input options_t exp);
        pulse(behaviour_setting_query_in);
        chkb(setting_valid_out, 1'h1);
        chk(16'(setting_reply_out), 16'(exp));
    endtask

    // ======================================
    // scenarios
    task automatic t_reset;
        @(negedge clk_in);
        chkb(output_on_out, 1'h0);
        chkb(voltage_mode_out, 1'h1);
        qset(3'h0);
    endtask
    task automatic t_codes;
        logic [15:0] codes [16] = '{ERR_COMMAND, ERR_MISSING, ERR_NUMERIC, ERR_PROTECTED,
            ERR_CONFLICT, ERR_CONFLICT, ERR_RANGE, ERR_TOO_MUCH, ERR_LIST_LEN, ERR_HARDWARE,
            ERR_DISCOVERY, ERR_VOLTAGE, ERR_CURRENT, ERR_MEMORY, ERR_QUERY, ERR_UNTERM};
        logic [7:0] bits [16] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
            8'h10, 8'h10, 8'h00, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04};
        for (int i = 0; i < 16; i++) begin
            pulse(status_clear_in);
            fire(events_t'(16'h8000 >> i));
            chk(16'(event_status_out), 16'(bits[i]));
            chkb(command_reject_out, i == 3);
            chkb(response_drop_out, i == 14);
            pop(codes[i]);
        end
        protected_access_unlock_in = 1'h1;
        calibration_state_in = 1'h1;
        step_hold_count_in = 8'h05;
        pulse(status_clear_in);
        fire(events_t'(16'h1880));
        chk(16'(event_status_out), 16'h0000);
        pop(ERR_NONE);
    endtask
    task automatic t_overflow;
        pulse(status_clear_in);
        for (int i = 0; i <= DEPTH; i++) begin
            fire(events_t'(i[0] ? 16'h0004 : 16'h8000));
        end
        chk(16'(event_status_out), 16'h0028);
        for (int i = 0; i < DEPTH; i++) begin
            pop(i == DEPTH - 1 ? ERR_OVERFLOW : i[0] ? ERR_MEMORY : ERR_COMMAND);
        end
        pop(ERR_NONE);
    endtask
    task automatic t_options;
        options_t exp = 3'h0;
        for (int c = 0; c < 8; c++) begin
            setting_code_in = setting_code_t'(c);
            pulse(behaviour_setting_command_in);
            if (c < 2) exp = c[0] ? 3'h7 : 3'h0;
            else exp[3 - c / 2] = c[0];
            qset(exp);
        end
        @(negedge clk_in) security_immediate_command_in = 1'h1;
        @(negedge clk_in) security_immediate_command_in = 1'h0;
        empty_read_in = 1'h1;
        @(negedge clk_in) empty_read_in = 1'h0;
        chkb(read_valid_out, 1'h1);
        chk(16'(read_char_out), 16'h000A);
        qset(3'h2);
        setting_code_in = SET_NL_OFF;
        pulse(behaviour_setting_command_in);
        pulse(empty_read_in);
        chkb(read_valid_out, 1'h0);
    endtask
    task automatic t_output;
        setting_code_in = SET_STANDARDS;
        pulse(behaviour_setting_command_in);
        pulse(output_on_cmd_in);
        pulse(reset_cmd_in);
        chkb(output_on_out, 1'h0);
        chkb(setpoint_zero_out, 1'h1);
        setting_code_in = SET_OUT_ON;
        pulse(behaviour_setting_command_in);
        pulse(reset_cmd_in);
        chkb(output_on_out, 1'h1);
        pulse(output_off_cmd_in);
        chkb(output_on_out, 1'h0);
        pulse(output_on_cmd_in);
        output_error_check_mode_in = 2'h0;
        fire(events_t'(16'h0008));
        chkb(output_on_out, 1'h1);
        output_error_check_mode_in = 2'h1;
        fire(events_t'(16'h0008));
        chkb(output_on_out, 1'h0);
        pulse(output_on_cmd_in);
        pulse(device_clear_in);
        chkb(output_on_out, 1'h1);
        chk(16'(event_status_out), 16'h0000);
        pop(ERR_NONE);
        setting_code_in = SET_OUT_OFF;
        pulse(behaviour_setting_command_in);
        setting_code_in = SET_CLR_RESET;
        pulse(behaviour_setting_command_in);
        pulse(device_clear_in);
        chkb(output_on_out, 1'h0);
        chkb(voltage_mode_out, 1'h1);
    endtask
    task automatic t_version;
        pulse(version_query_in);
        chkb(version_valid_out, 1'h1);
        chk(version_year_out, 16'h07CD);
        chk(16'(version_rev_out), 16'h0000);
        @(negedge clk_in);
        chk(16'(replies), 16'h000B);
    endtask

    // ======================================
    // verdict
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(negedge clk_in);
        chkb(setpoint_zero_out, 1'h1);
        rst_b_in = 1'h1;
        t_reset();
        t_codes();
        t_overflow();
        t_options();
        t_output();
        t_version();
        wrap_up();
    end

    // hang guard, well past the expected run
    initial begin
        #500000;
        num_errors++;
        wrap_up();
    end
endmodule
